//--- rtl/fpce_params.svh
`ifndef FPCE_PARAMS_SVH
`define FPCE_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define FPCE_CLK_NS     10
`define FPCE_TWP_NS     35
`define FPCE_TACC_NS    90
`define FPCE_TRP_NS     500
`define FPCE_TWP_CYC    ((`FPCE_TWP_NS + `FPCE_CLK_NS - 1) / `FPCE_CLK_NS)
`define FPCE_TACC_CYC   ((`FPCE_TACC_NS + `FPCE_CLK_NS - 1) / `FPCE_CLK_NS)
`define FPCE_TRP_CYC    ((`FPCE_TRP_NS + `FPCE_CLK_NS - 1) / `FPCE_CLK_NS)
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define FPCE_REG_CMD    8'h00
`define FPCE_REG_CFG    8'h04
`define FPCE_REG_ADDR   8'h08
`define FPCE_REG_DATA   8'h0C
`define FPCE_REG_COUNT  8'h10
`define FPCE_REG_STAT   8'h14
`define FPCE_REG_RDATA  8'h18
`define FPCE_REG_BUF    8'h40
`define FPCE_CFG_ACCEL  0
`define FPCE_CFG_BYTE   1
`define FPCE_BUF_WORDS  16
// ----------------------------------------
// Operation codes written to CMD
// ----------------------------------------
`define FPCE_OP_WORD      4'h1
`define FPCE_OP_BYP_ENTER 4'h2
`define FPCE_OP_BYP_PROG  4'h3
`define FPCE_OP_BYP_EXIT  4'h4
`define FPCE_OP_BUF       4'h5
`define FPCE_OP_ABORT_RST 4'h6
`define FPCE_OP_SEC_ENTER 4'h7
`define FPCE_OP_SEC_EXIT  4'h8
`define FPCE_OP_READ      4'h9
`define FPCE_OP_HWRESET   4'hA
// ----------------------------------------
// Flash command cycles, sector mask and status bits
// ----------------------------------------
`define FPCE_UL1_ADDR   23'h000555
`define FPCE_UL1_DATA   16'h00AA
`define FPCE_UL2_ADDR   23'h0002AA
`define FPCE_UL2_DATA   16'h0055
`define FPCE_C_PROG     16'h00A0
`define FPCE_C_BYP      16'h0020
`define FPCE_C_BYPX1    16'h0090
`define FPCE_C_BYPX2    16'h0000
`define FPCE_C_LOAD     16'h0025
`define FPCE_C_CONFIRM  16'h0029
`define FPCE_C_ABORTRST 16'h00F0
`define FPCE_C_SECIN    16'h0088
`define FPCE_C_SECX1    16'h0090
`define FPCE_C_SECX2    16'h0000
`define FPCE_SECT_MASK  23'h7F8000
`define FPCE_DQ_POLL    7
`define FPCE_DQ_TOGGLE  6
`define FPCE_DQ_TIMEOUT 5
`define FPCE_DQ_ABORT   1
`endif

//--- rtl/fpce_pkg.sv
package fpce_pkg;
	typedef enum logic [2:0] {E_IDLE, E_STEP, E_WAITW, E_POLL, E_POLLW, E_READ, E_READW,
		E_RESET} fpce_eng_e;
	typedef enum logic [1:0] {B_IDLE, B_SETUP, B_PULSE, B_HOLD} fpce_bus_e;
	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] data;
		logic        last;
	} fpce_step_s;
endpackage

//--- rtl/fpce_if.sv
`timescale 1ns/1ps
interface fpce_if;
	logic        req;
	logic        wr;
	logic        kill;
	logic [22:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport eng (output req, wr, kill, addr, wdata, input done, rdata);
	modport phy (input req, wr, kill, addr, wdata, output done, rdata);
endinterface

//--- rtl/fpce_axil.sv
`timescale 1ns/1ps
module fpce_axil (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic             rvalid,
	input  wire logic        rready,
	// Register side
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	input  wire logic [31:0] rd_data
);
	logic aw_h;
	logic w_h;
	logic [3:0] strb;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h    <= 1'b0;
			w_h     <= 1'b0;
			wr_en   <= 1'b0;
			bvalid  <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			strb    <= 4'h0;
		end else begin
			wr_en <= 1'b0;
			if (awvalid && awready) begin
				aw_h    <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_h     <= 1'b1;
				wr_data <= wdata;
				strb    <= wstrb;
			end
			// Partial writes are dropped: every register is one whole word
			if (aw_h && w_h && !bvalid) begin
				wr_en  <= (strb == 4'hF);
				bvalid <= 1'b1;
				aw_h   <= 1'b0;
				w_h    <= 1'b0;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	assign awready = !aw_h && !bvalid;
	assign wready  = !w_h && !bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	assign arready = !rvalid;
endmodule // fpce_axil

//--- rtl/fpce_bus.sv
`timescale 1ns/1ps
`include "fpce_params.svh"
module fpce_bus (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Cycle requests
	fpce_if.phy              cyc,
	// Flash pins
	output logic [22:0]      fl_addr,
	output logic [15:0]      fl_dq_o,
	output logic             fl_dq_oe,
	input  wire logic [15:0] fl_dq_i,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n
);
	fpce_pkg::fpce_bus_e st;
	logic [7:0] cnt;
	logic       wr_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || cyc.kill) begin
			st        <= fpce_pkg::B_IDLE;
			cnt       <= 8'h00;
			wr_r      <= 1'b0;
			fl_addr   <= 23'h000000;
			fl_dq_o   <= 16'h0000;
			fl_dq_oe  <= 1'b0;
			fl_ce_n   <= 1'b1;
			fl_oe_n   <= 1'b1;
			fl_we_n   <= 1'b1;
			cyc.done  <= 1'b0;
			cyc.rdata <= 16'h0000;
		end else begin
			cyc.done <= 1'b0;
			if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			case (st)
				fpce_pkg::B_IDLE: if (cyc.req) begin
					fl_addr  <= cyc.addr;
					fl_dq_o  <= cyc.wdata;
					fl_dq_oe <= cyc.wr;
					wr_r     <= cyc.wr;
					fl_ce_n  <= 1'b0;
					st       <= fpce_pkg::B_SETUP;
				end
				// Address is stable a cycle before the strobe falls
				fpce_pkg::B_SETUP: begin
					fl_we_n <= !wr_r;
					fl_oe_n <= wr_r;
					cnt     <= wr_r ? 8'(`FPCE_TWP_CYC - 1) : 8'(`FPCE_TACC_CYC - 1);
					st      <= fpce_pkg::B_PULSE;
				end
				fpce_pkg::B_PULSE: if (cnt == 8'h00) begin
					fl_we_n   <= 1'b1;
					fl_oe_n   <= 1'b1;
					cyc.rdata <= fl_dq_i;
					st        <= fpce_pkg::B_HOLD;
				end
				fpce_pkg::B_HOLD: begin
					fl_ce_n  <= 1'b1;
					fl_dq_oe <= 1'b0;
					cyc.done <= 1'b1;
					st       <= fpce_pkg::B_IDLE;
				end
				default: st <= fpce_pkg::B_IDLE;
			endcase
		end
	end
endmodule // fpce_bus

//--- rtl/fpce_top.sv
`timescale 1ns/1ps
`include "fpce_params.svh"
module fpce_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Flash pins
	output logic [22:0]      fl_addr,
	output logic [15:0]      fl_dq_o,
	output logic             fl_dq_oe,
	input  wire logic [15:0] fl_dq_i,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	output logic             fl_reset_n,
	output logic             fl_accel_hv
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic        axi_awready;
	logic        axi_wready;
	logic        axi_arready;
	fpce_if      cyc ();

	fpce_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (axi_wready),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (axi_arready),
		.rdata   (s_axi_rdata),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_data (rd_data)
	);

	fpce_bus u_bus (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.cyc      (cyc),
		.fl_addr  (fl_addr),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe),
		.fl_dq_i  (fl_dq_i),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n)
	);

	// Ready lines are registered terms of the slave, combined only in fpce_axil
	assign s_axi_awready = axi_awready;
	assign s_axi_wready  = axi_wready;
	assign s_axi_arready = axi_arready;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_rresp   = 2'h0;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic [22:0] tgt_addr;
	logic [15:0] tgt_data;
	logic [4:0]  buf_cnt;
	logic        byte_mode;
	logic [15:0] rd_word;
	logic [15:0] buf_mem [`FPCE_BUF_WORDS];
	logic        busy;
	logic        bypass;
	logic        secured;
	logic        done_f;
	logic        tmo_f;
	logic        abort_f;
	logic        refused;
	fpce_pkg::fpce_eng_e st;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tgt_addr <= 23'h000000;
			tgt_data <= 16'hFFFF;
			buf_cnt  <= 5'h00;
			byte_mode <= 1'b0;
		end else if (wr_en && !busy) begin
			if (reg_hit(wr_addr, `FPCE_REG_ADDR))
				tgt_addr <= wr_data[22:0];
			if (reg_hit(wr_addr, `FPCE_REG_DATA))
				tgt_data <= wr_data[15:0];
			if (reg_hit(wr_addr, `FPCE_REG_COUNT))
				buf_cnt <= wr_data[4:0];
			if (reg_hit(wr_addr, `FPCE_REG_CFG))
				byte_mode <= wr_data[`FPCE_CFG_BYTE];
		end
	end

	// Later loads of one slot overwrite earlier ones, as the device does
	for (genvar g = 0; g < `FPCE_BUF_WORDS; g++) begin : g_buf
		always_ff @(posedge aclk) begin
			if (!aresetn)
				buf_mem[g] <= 16'hFFFF;
			else if (wr_en && !busy && reg_hit(wr_addr, 8'(`FPCE_REG_BUF + 4 * g)))
				buf_mem[g] <= wr_data[15:0];
		end
	end

	// High voltage is switched on only while idle, and is held off while secured
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fl_accel_hv <= 1'b0;
		else if (wr_en && !busy && reg_hit(wr_addr, `FPCE_REG_CFG))
			fl_accel_hv <= wr_data[`FPCE_CFG_ACCEL] && !secured;
		else if (secured)
			fl_accel_hv <= 1'b0;
	end

	always_comb begin
		rd_data = 32'h00000000;
		if (reg_hit(s_axi_araddr, `FPCE_REG_CFG))
			rd_data = {30'h0, byte_mode, fl_accel_hv};
		else if (reg_hit(s_axi_araddr, `FPCE_REG_ADDR))
			rd_data = {9'h0, tgt_addr};
		else if (reg_hit(s_axi_araddr, `FPCE_REG_DATA))
			rd_data = {16'h0, tgt_data};
		else if (reg_hit(s_axi_araddr, `FPCE_REG_COUNT))
			rd_data = {27'h0, buf_cnt};
		else if (reg_hit(s_axi_araddr, `FPCE_REG_STAT))
			rd_data = {23'h0, !fl_reset_n, fl_accel_hv, refused, secured,
				bypass || fl_accel_hv, abort_f, tmo_f, done_f, busy};
		else if (reg_hit(s_axi_araddr, `FPCE_REG_RDATA))
			rd_data = {16'h0, rd_word};
	end

	// ----------------------------------------
	// Command sequences
	// ----------------------------------------
	function automatic fpce_pkg::fpce_step_s seq_step(input logic [3:0] op,
		input logic [4:0] i, input logic [22:0] tgt, input logic [15:0] dat,
		input logic [4:0] cnt, input logic [15:0] bw);
		fpce_pkg::fpce_step_s s;
		logic [22:0] sec;
		logic [4:0]  k;
		sec    = tgt & `FPCE_SECT_MASK;
		k      = i - 5'h04;
		s.last = 1'b0;
		s.addr = (i == 5'h01) ? `FPCE_UL2_ADDR : `FPCE_UL1_ADDR;
		s.data = (i == 5'h01) ? `FPCE_UL2_DATA : `FPCE_UL1_DATA;
		case (op)
			`FPCE_OP_WORD: begin
				if (i == 5'h02)
					s.data = `FPCE_C_PROG;
				if (i == 5'h03) begin
					s = '{tgt, dat, 1'b1};
				end
			end
			`FPCE_OP_BYP_ENTER: if (i == 5'h02)
				s = '{`FPCE_UL1_ADDR, `FPCE_C_BYP, 1'b1};
			`FPCE_OP_BYP_PROG: begin
				if (i == 5'h00)
					s.data = `FPCE_C_PROG;
				else
					s = '{tgt, dat, 1'b1};
			end
			`FPCE_OP_BYP_EXIT: begin
				s.addr = `FPCE_UL1_ADDR;
				s.data = (i == 5'h00) ? `FPCE_C_BYPX1 : `FPCE_C_BYPX2;
				s.last = (i != 5'h00);
			end
			`FPCE_OP_SEC_ENTER: if (i == 5'h02)
				s = '{`FPCE_UL1_ADDR, `FPCE_C_SECIN, 1'b1};
			`FPCE_OP_SEC_EXIT: begin
				if (i == 5'h02)
					s.data = `FPCE_C_SECX1;
				if (i == 5'h03)
					s = '{`FPCE_UL1_ADDR, `FPCE_C_SECX2, 1'b1};
			end
			`FPCE_OP_ABORT_RST: if (i == 5'h02)
				s = '{`FPCE_UL1_ADDR, `FPCE_C_ABORTRST, 1'b1};
			`FPCE_OP_BUF: begin
				if (i == 5'h02)
					s = '{sec, `FPCE_C_LOAD, 1'b0};
				else if (i == 5'h03)
					s = '{sec, {11'h0, cnt}, 1'b0};
				else if (i >= 5'h04 && {1'b0, i} <= {1'b0, cnt} + 6'h04)
					s = '{{tgt[22:4], k[3:0]}, bw, 1'b0};
				else if (i > 5'h03)
					s = '{sec, `FPCE_C_CONFIRM, 1'b1};
			end
			default: s.last = 1'b1;
		endcase
		seq_step = s;
	endfunction

	// ----------------------------------------
	// Acceptance of commands
	// ----------------------------------------
	logic       cmd_wr;
	logic [3:0] op_in;
	logic       op_ok;
	assign cmd_wr = wr_en && reg_hit(wr_addr, `FPCE_REG_CMD);
	assign op_in  = wr_data[3:0];

	always_comb begin
		case (op_in)
			`FPCE_OP_WORD:      op_ok = !bypass && !fl_accel_hv && !byte_mode;
			`FPCE_OP_BYP_ENTER: op_ok = !bypass && !fl_accel_hv && !secured;
			`FPCE_OP_BYP_PROG:  op_ok = (bypass || fl_accel_hv) && !secured;
			`FPCE_OP_BYP_EXIT:  op_ok = bypass && !fl_accel_hv;
			`FPCE_OP_BUF:       op_ok = !secured && buf_cnt < 5'(`FPCE_BUF_WORDS);
			`FPCE_OP_SEC_ENTER: op_ok = !bypass && !fl_accel_hv && !secured;
			`FPCE_OP_SEC_EXIT:  op_ok = secured && !bypass;
			`FPCE_OP_ABORT_RST: op_ok = 1'b1;
			`FPCE_OP_READ:      op_ok = 1'b1;
			default:            op_ok = 1'b0;
		endcase
		// After an abort only the abort reset, a read or the hardware reset is accepted
		if (abort_f && op_in != `FPCE_OP_ABORT_RST && op_in != `FPCE_OP_READ)
			op_ok = 1'b0;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic [3:0]  op_r;
	logic [4:0]  idx;
	logic [4:0]  boff;
	logic [7:0]  rst_cnt;
	logic        have_prev;
	logic [15:0] prev;
	logic [22:0] poll_addr;
	logic        polled;
	fpce_pkg::fpce_step_s step;

	assign boff      = idx - 5'h04;
	assign step      = seq_step(op_r, idx, tgt_addr, tgt_data, buf_cnt, buf_mem[boff[3:0]]);
	assign poll_addr = (op_r == `FPCE_OP_BUF) ? {tgt_addr[22:4], buf_cnt[3:0]} : tgt_addr;
	assign polled    = op_r == `FPCE_OP_WORD || op_r == `FPCE_OP_BYP_PROG
		|| op_r == `FPCE_OP_BUF;
	assign busy      = st != fpce_pkg::E_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st         <= fpce_pkg::E_IDLE;
			op_r       <= 4'h0;
			idx        <= 5'h00;
			rst_cnt    <= 8'h00;
			have_prev  <= 1'b0;
			prev       <= 16'h0000;
			rd_word    <= 16'h0000;
			bypass     <= 1'b0;
			secured    <= 1'b0;
			done_f     <= 1'b0;
			tmo_f      <= 1'b0;
			abort_f    <= 1'b0;
			refused    <= 1'b0;
			fl_reset_n <= 1'b1;
			cyc.req    <= 1'b0;
			cyc.wr     <= 1'b0;
			cyc.kill   <= 1'b0;
			cyc.addr   <= 23'h000000;
			cyc.wdata  <= 16'h0000;
		end else begin
			cyc.req  <= 1'b0;
			cyc.kill <= 1'b0;
			if (cmd_wr && op_in == `FPCE_OP_HWRESET) begin
				// Reset always wins, even in the middle of programming
				st         <= fpce_pkg::E_RESET;
				cyc.kill   <= 1'b1;
				fl_reset_n <= 1'b0;
				rst_cnt    <= 8'(`FPCE_TRP_CYC - 1);
				done_f     <= 1'b0;
				refused    <= 1'b0;
			end else if (cmd_wr && busy) begin
				refused <= 1'b1;
			end else if (cmd_wr) begin
				refused <= !op_ok;
				if (op_ok) begin
					op_r      <= op_in;
					idx       <= 5'h00;
					have_prev <= 1'b0;
					done_f    <= 1'b0;
					tmo_f     <= 1'b0;
					st        <= (op_in == `FPCE_OP_READ) ? fpce_pkg::E_READ : fpce_pkg::E_STEP;
				end
			end else begin
				case (st)
					fpce_pkg::E_STEP: begin
						cyc.req   <= 1'b1;
						cyc.wr    <= 1'b1;
						cyc.addr  <= step.addr;
						cyc.wdata <= step.data;
						st        <= fpce_pkg::E_WAITW;
					end
					fpce_pkg::E_WAITW: if (cyc.done) begin
						idx <= idx + 5'h01;
						if (!step.last) begin
							st <= fpce_pkg::E_STEP;
						end else if (polled) begin
							st <= fpce_pkg::E_POLL;
						end else begin
							st     <= fpce_pkg::E_IDLE;
							done_f <= 1'b1;
							case (op_r)
								`FPCE_OP_BYP_ENTER: bypass <= 1'b1;
								`FPCE_OP_BYP_EXIT:  bypass <= 1'b0;
								`FPCE_OP_SEC_ENTER: secured <= 1'b1;
								`FPCE_OP_SEC_EXIT:  secured <= 1'b0;
								`FPCE_OP_ABORT_RST: abort_f <= 1'b0;
								default: ;
							endcase
						end
					end
					fpce_pkg::E_POLL, fpce_pkg::E_READ: begin
						cyc.req  <= 1'b1;
						cyc.wr   <= 1'b0;
						cyc.addr <= (st == fpce_pkg::E_READ) ? tgt_addr : poll_addr;
						st <= (st == fpce_pkg::E_READ) ? fpce_pkg::E_READW : fpce_pkg::E_POLLW;
					end
					fpce_pkg::E_READW: if (cyc.done) begin
						rd_word <= cyc.rdata;
						done_f  <= 1'b1;
						st      <= fpce_pkg::E_IDLE;
					end
					// Two reads in a row: a steady toggle bit means the device is back
					fpce_pkg::E_POLLW: if (cyc.done) begin
						prev      <= cyc.rdata;
						have_prev <= 1'b1;
						st        <= fpce_pkg::E_POLL;
						if (have_prev && prev[`FPCE_DQ_TOGGLE] == cyc.rdata[`FPCE_DQ_TOGGLE]) begin
							rd_word <= cyc.rdata;
							done_f  <= 1'b1;
							st      <= fpce_pkg::E_IDLE;
						end else if (have_prev && prev[`FPCE_DQ_ABORT] && op_r == `FPCE_OP_BUF
							&& cyc.rdata[`FPCE_DQ_ABORT] && !cyc.rdata[`FPCE_DQ_TIMEOUT]) begin
							abort_f <= 1'b1;
							done_f  <= 1'b1;
							st      <= fpce_pkg::E_IDLE;
						end else if (have_prev && prev[`FPCE_DQ_TIMEOUT] && cyc.rdata[`FPCE_DQ_TIMEOUT]) begin
							// Also the mark of a try to turn a zero into a one
							tmo_f  <= 1'b1;
							done_f <= 1'b1;
							st     <= fpce_pkg::E_IDLE;
						end
					end
					fpce_pkg::E_RESET: begin
						if (rst_cnt != 8'h00) begin
							rst_cnt <= rst_cnt - 8'h01;
						end else begin
							fl_reset_n <= 1'b1;
							bypass     <= 1'b0;
							secured    <= 1'b0;
							abort_f    <= 1'b0;
							done_f     <= 1'b1;
							st         <= fpce_pkg::E_IDLE;
						end
					end
					default: st <= fpce_pkg::E_IDLE;
				endcase
			end
		end
	end
endmodule // fpce_top

//--- dv/fpce_top_props.sv
`timescale 1ns/1ps
module fpce_top_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Watched outputs
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [22:0] fl_addr,
	input wire logic [15:0] fl_dq_o,
	input wire logic        fl_dq_oe,
	input wire logic        fl_ce_n,
	input wire logic        fl_oe_n,
	input wire logic        fl_we_n,
	input wire logic        fl_reset_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Strobe shapes
	// ----------------------------------------
	sequence we_pulse_s;
		!fl_we_n [*4] ##1 fl_we_n;
	endsequence
	sequence oe_pulse_s;
		!fl_oe_n [*8];
	endsequence
	chk_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> fl_we_n && fl_ce_n && !fl_dq_oe && !s_axi_bvalid)
		else $error("strobes not idle after reset");
	chk_we_width: assert property ($fell(fl_we_n) |-> !fl_ce_n && fl_dq_oe ##0 we_pulse_s)
		else $error("write strobe shape wrong");
	chk_we_stable: assert property (!fl_we_n ##1 !fl_we_n |->
		$stable(fl_addr) && $stable(fl_dq_o))
		else $error("address or data moved during write strobe");
	chk_no_fight: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n && fl_we_n)
		else $error("read while host drives data");
	chk_read_width: assert property ($fell(fl_oe_n) |-> oe_pulse_s)
		else $error("read strobe too short");
	chk_reset_pulse: assert property ($fell(fl_reset_n) |-> !fl_reset_n [*8])
		else $error("flash reset pulse too short");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	chk_resp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	chk_ce_frame: assert property ($rose(fl_ce_n) |-> fl_we_n && fl_oe_n)
		else $error("chip select left before strobe");
endmodule // fpce_top_props
bind fpce_top fpce_top_props u_props (.*);

//--- dv/fpce_flash_model.sv
`timescale 1ns/1ps
`include "fpce_params.svh"
module fpce_flash_model (
	// Flash pins
	input  wire logic [22:0] fl_addr,
	input  wire logic [15:0] fl_dq_o,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_oe_n,
	input  wire logic        fl_we_n,
	input  wire logic        fl_reset_n,
	input  wire logic        fl_accel_hv,
	output logic      [15:0] fl_dq_i,
	// Fault injection
	input  wire logic        force_abort
);
	logic [15:0] mem [int];
	logic [15:0] bufd [int];
	logic [15:0] ld = 16'h0000, lq = 16'h0000, d;
	logic [22:0] sa, pg, a;
	logic        tog = 0, abrt = 0, byp = 0, sec = 0, pgv;
	int          st = 0, busy = 0, left;
	function automatic logic [15:0] rd(input logic [22:0] x);
		return mem.exists(x) ? mem[x] : 16'hFFFF;
	endfunction
	always @(negedge fl_reset_n) begin
		st = 0;
		busy = 0;
		{abrt, byp, sec} = 3'h0;
	end
	// Writes while programming are dropped
	always @(posedge fl_we_n) if (!fl_ce_n && fl_reset_n && busy == 0) begin
		a = fl_addr;
		d = fl_dq_o;
		case (st)
		0: if ((byp || fl_accel_hv) && !sec) st = d == 16'h00A0 ? 3 : d == 16'h0090 ? 8 : 0;
			else if (a == `FPCE_UL1_ADDR && d == `FPCE_UL1_DATA) st = 1;
		1: st = (a == `FPCE_UL2_ADDR && d == `FPCE_UL2_DATA) ? 2 : 0;
		2: begin
			st = 0;
			if (abrt) abrt = d != `FPCE_C_ABORTRST;
			else if (d == `FPCE_C_PROG) st = 3;
			else if (d == `FPCE_C_BYP) byp = !sec;
			else if (d == `FPCE_C_SECIN) sec = 1;
			else if (d == `FPCE_C_SECX1 && sec) st = 9;
			else if (d == `FPCE_C_LOAD && !sec) begin
				st = 5;
				sa = a;
				pgv = 0;
				bufd.delete();
			end
		end
		3: begin
			mem[a] = rd(a) & d;
			ld = d;
			pg = a;
			busy = 4;
			st = 0;
		end
		5: begin
			left = d;
			abrt = d > 16'h000F;
			st = abrt ? 0 : 6;
		end
		6: begin
			if (!pgv) pg = a;
			pgv = 1;
			abrt = a[22:4] != pg[22:4] || (a & `FPCE_SECT_MASK) != (sa & `FPCE_SECT_MASK);
			ld = d;
			bufd[a] = d;
			left--;
			st = abrt ? 0 : left < 0 ? 7 : 6;
		end
		7: begin
			st = 0;
			abrt = force_abort || d != `FPCE_C_CONFIRM;
			foreach (bufd[k]) if (!abrt) mem[k] = rd(k) & bufd[k];
			busy = abrt ? 0 : 4;
		end
		8: begin byp = d != `FPCE_C_BYPX2; st = 0; end
		9: begin sec = d != `FPCE_C_SECX2; st = 0; end
		default: st = 0;
		endcase
	end
	// Status until done, then array; inverse of last value when released
	always @* begin
		if (busy > 0 || abrt) fl_dq_i = {8'h00, ~ld[7], tog, 4'h0, abrt, 1'b0};
		else fl_dq_i = rd(fl_addr);
		if (fl_ce_n || fl_oe_n) fl_dq_i = ~lq;
	end
	always @(fl_dq_i) if (!fl_ce_n && !fl_oe_n) lq = fl_dq_i;
	always @(posedge fl_oe_n) begin
		tog = ~tog;
		if (busy > 0) busy--;
	end
endmodule // fpce_flash_model

//--- dv/flash_program_command_engine_tb_top.sv
`timescale 1ns/1ps
module flash_program_command_engine_tb_top;
	logic        aclk, aresetn, force_abort;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_accel_hv;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, stat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [22:0] fl_addr;
	logic [15:0] fl_dq_o, fl_dq_i;
	int          num_errors = 0, num_checks = 0, ref_mem [int];
	fpce_top uut (.*);
	fpce_flash_model u_flash (.*);
	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		finish_test();
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ap, wp;
		ap = 1;
		wp = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (ap || wp) begin
			@(posedge aclk);
			if (s_axi_awready && ap) s_axi_awvalid <= 0;
			if (s_axi_wready && wp) s_axi_wvalid <= 0;
			ap = ap && !s_axi_awready;
			wp = wp && !s_axi_wready;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		check("rresp", s_axi_rresp, 2'h0);
	endtask
	task automatic run(input logic [3:0] op);
		axi_wr(8'h00, {28'h0, op});
		stat = 32'h1;
		while (stat[0] || stat[8]) axi_rd(8'h14, stat);
	endtask
	task automatic prog(input logic [3:0] op, input logic [22:0] a, input logic [15:0] d);
		axi_wr(8'h08, {9'h0, a});
		axi_wr(8'h0C, {16'h0, d});
		run(op);
		ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 'hFFFF) & d;
	endtask
	task automatic rd_chk(input logic [22:0] a);
		logic [31:0] r;
		axi_wr(8'h08, {9'h0, a});
		run(4'h9);
		axi_rd(8'h18, r);
		check("array", r, ref_mem.exists(a) ? ref_mem[a] : 'hFFFF);
	endtask
	task automatic buf_prog(input logic [22:0] a, input int n);
		logic [15:0] d;
		axi_wr(8'h10, n);
		for (int i = 0; i < n + 1; i++) begin
			d = $urandom;
			axi_wr(8'h40 + 8'(4 * i), {16'h0, d});
			if (!force_abort) ref_mem[a + i] = (ref_mem.exists(a + i) ? ref_mem[a + i] : 'hFFFF) & d;
		end
		axi_wr(8'h08, {9'h0, a});
		run(4'h5);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [22:0] a;
		logic [15:0] d;
		logic [31:0] r;
		{aresetn, force_abort, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(83801));
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axi_rd(8'h14, r);
		check("stat_reset", r[8:0], 9'h000);
		a = $urandom;
		d = $urandom;
		prog(4'h1, a, d);
		prog(4'h1, a, ~d | 16'h00F0);
		rd_chk(a);
		axi_wr(8'h04, 32'h2);
		run(4'h1);
		check("byte_refused", stat[6], 1);
		axi_wr(8'h04, 32'h0);
		run(4'h2);
		check("bypass_on", stat[4], 1);
		for (int i = 0; i < 2; i++) prog(4'h3, a + 23'(i), $urandom);
		run(4'h1);
		check("bypass_refused", stat[6], 1);
		run(4'h4);
		check("bypass_off", stat[4], 0);
		rd_chk(a + 23'h1);
		run(4'h7);
		check("secure_on", stat[5], 1);
		run(4'h5);
		check("secure_refused", stat[6], 1);
		run(4'h8);
		check("secure_off", stat[5], 0);
		axi_wr(8'h04, 32'h1);
		prog(4'h3, a + 23'h2, $urandom);
		check("accel", stat[7], 1);
		axi_wr(8'h04, 32'h0);
		rd_chk(a + 23'h2);
		a = $urandom & 23'h7FFFF0;
		buf_prog(a, 15);
		check("buf_done", stat[1], 1);
		for (int i = 0; i < 16; i += 5) rd_chk(a + 23'(i));
		axi_wr(8'h10, 32'h10);
		run(4'h5);
		check("oversize", stat[6], 1);
		force_abort <= 1;
		buf_prog(a, 1);
		check("abort_set", stat[3:2], 2'h2);
		force_abort <= 0;
		run(4'h6);
		check("abort_clear", stat[3], 0);
		rd_chk(a);
		axi_wr(8'h00, 32'hA);
		axi_rd(8'h14, r);
		check("hw_reset", r[8], 1);
		run(4'h9);
		axi_rd(8'h30, r);
		check("unmapped", r, 32'h0);
		finish_test();
	end
endmodule // flash_program_command_engine_tb_top
